// >>> design/pcs_fifo.sv
// pcs_fifo: speed-matching word fifo with valid/ready on both sides
// assumes: one clock, synchronous active-low reset, flush has priority
module pcs_fifo
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        flush,
    input  wire logic                        in_valid,
    output logic                             in_ready,
    input  wire logic [pcs_pkg::WORD_W-1:0]  in_data,
    output logic                             out_valid,
    input  wire logic                        out_ready,
    output logic      [pcs_pkg::WORD_W-1:0]  out_data
);
    logic [pcs_pkg::WORD_W-1:0] mem [pcs_pkg::FIFO_DEPTH];
    logic [pcs_pkg::FIFO_AW:0]  wr_r;
    logic [pcs_pkg::FIFO_AW:0]  rd_r;
    logic                       push;
    logic                       pop;

    // extra pointer bit tells full from empty
    assign in_ready  = (wr_r - rd_r) != (pcs_pkg::FIFO_AW+1)'(pcs_pkg::FIFO_DEPTH);
    assign out_valid = wr_r != rd_r;
    assign out_data  = mem[rd_r[pcs_pkg::FIFO_AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || flush)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_r[pcs_pkg::FIFO_AW-1:0]] <= in_data;
    end
endmodule

// >>> design/pcs_pkg.sv
// pcs_pkg: shared register map, field positions, frame codes and carrier structs
// assumes: 32-bit APB slave, one word per register, 40 MHz core clock
package pcs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CMDBLK  = 8'h00; // feature/sector/lba/device/command block
    localparam logic [7:0] REG_CTRL    = 8'h04; // device control byte
    localparam logic [7:0] REG_STATUS  = 8'h08; // shadow status (read) / err in 15:8
    localparam logic [7:0] REG_CMD     = 8'h0C; // command byte, write issues the frame
    localparam logic [7:0] REG_DATA    = 8'h10; // 16-bit shadow data port
    localparam logic [7:0] REG_DMACTL  = 8'h14; // bit0 run, bit1 direction (1 = to memory)
    localparam logic [7:0] REG_IRQSTAT = 8'h18; // sticky events, write one to clear
    localparam logic [7:0] REG_IRQMASK = 8'h1C; // event enables
    localparam logic [7:0] REG_XFER    = 8'h20; // announced word count, phase
    // status bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRQ = 3;
    // interrupt event bits
    localparam int EV_SETUP = 0; // setup frame with interrupt flag applied
    localparam int EV_DONE  = 1; // completion register frame with interrupt flag
    localparam int EV_NUM   = 2;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    // fifo geometry
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;
    localparam int WORD_W     = 16;
    // incoming frame kinds
    typedef enum logic [1:0]
    {
        FR_REG_D2H = 2'h0,
        FR_PIO_SET = 2'h1,
        FR_DATA    = 2'h2
    } pcs_frame_t;
    // header of an incoming register or setup frame
    typedef struct packed
    {
        logic [7:0]  status;   // beginning status for setup, status for register frame
        logic [7:0]  e_status; // ending status, setup frames only
        logic [7:0]  error;
        logic [15:0] count;    // words announced, setup frames only
        logic        dir_in;   // 1 = toward host
        logic        irq;      // header interrupt flag
        logic [31:0] regs;     // lba/sector bytes for the command block
    } pcs_hdr_t;
    // outgoing register host-to-device frame
    typedef struct packed
    {
        logic [31:0] cmdblk;
        logic [7:0]  ctrl;
        logic [7:0]  command;
    } pcs_h2d_t;
endpackage

// >>> design/pcs_top.sv
// pcs_top: packet command shadow sequencer of a serial host adapter
// assumes: APB master on core_clk; link layer delivers decoded frames as strobes
module pcs_top
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic                            irq,
    output logic                            h2d_valid,
    output pcs_pkg::pcs_h2d_t               h2d_frame,
    input  wire logic                       h2d_ack,
    input  wire logic                       rx_hdr_valid,
    input  wire pcs_pkg::pcs_frame_t        rx_kind,
    input  wire pcs_pkg::pcs_hdr_t          rx_hdr,
    input  wire logic                       rx_dvalid,
    output logic                            rx_dready,
    input  wire logic [15:0]                rx_dword,
    output logic                            tx_dvalid,
    input  wire logic                       tx_dready,
    output logic      [15:0]                tx_dword,
    output logic                            tx_eof,
    output logic                            dma_valid,
    output logic      [15:0]                dma_word,
    input  wire logic                       dma_ready
);
    typedef enum logic [1:0]
    {
        PH_IDLE = 2'b00,
        PH_OUT  = 2'b01,
        PH_IN   = 2'b11,
        PH_DMA  = 2'b10
    } pcs_phase_t;

    localparam int EV_W = pcs_pkg::EV_NUM;

    pcs_phase_t  phase_r;
    logic [31:0] cmdblk_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  cmd_r;
    logic [7:0]  status_r;
    logic [7:0]  error_r;
    logic        dma_run_r;
    logic        dma_dir_r;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] mask_r;
    logic        held_r;
    pcs_pkg::pcs_hdr_t hold_r;
    logic [15:0] cnt_r;
    logic [15:0] done_r;
    logic        eof_r;
    logic [31:0] rdata_nxt;
    logic [15:0] sent_r;

    // apb decode; every access completes in its first access cycle
    logic wr_acc;
    logic rd_acc;
    logic known;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign known  = paddr[1:0] == 2'b00 && paddr <= pcs_pkg::REG_XFER;

    // transmit fifo ports
    logic tx_in_ready;
    logic tx_push;
    logic tx_out_valid;
    logic [15:0] tx_out_data;
    logic tx_pop;
    // receive fifo ports
    logic rx_in_ready;
    logic rx_push;
    logic rx_out_valid;
    logic [15:0] rx_out_data;
    logic rx_pop;
    logic flush;
    logic to_dma;
    logic tx_dvalid_hold;
    logic dma_take;
    logic dma_valid_nxt;

    // a stalled data write is refused rather than waited on, keeping pready one cycle
    assign tx_push = wr_acc && paddr == pcs_pkg::REG_DATA && phase_r == PH_OUT
                     && status_r[pcs_pkg::ST_DRQ] && tx_in_ready;
    assign rx_pop  = rd_acc && paddr == pcs_pkg::REG_DATA && phase_r == PH_IN
                     && rx_out_valid;
    assign flush   = wr_acc && paddr == pcs_pkg::REG_CMD;
    assign to_dma  = phase_r == PH_DMA;
    // a word counts as taken only where the link saw our registered ready
    assign rx_push = !to_dma && rx_dvalid && rx_dready && phase_r == PH_IN && rx_in_ready;
    assign tx_dvalid_hold = tx_dvalid && !tx_dready;
    assign tx_pop  = tx_out_valid && !tx_dvalid_hold;

    pcs_fifo u_txf
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .flush     (flush),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (pwdata[15:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data)
    );

    pcs_fifo u_rxf
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .flush     (flush),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_dword),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data)
    );

    // link-side transmit staging; eof marks last word of the frame
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tx_dvalid <= 1'b0;
            tx_dword  <= 16'h0000;
            tx_eof    <= 1'b0;
        end
        else if (tx_pop)
        begin
            tx_dvalid <= 1'b1;
            tx_dword  <= tx_out_data;
            tx_eof    <= eof_r && (sent_r + 16'h0001 == cnt_r);
        end
        else if (tx_dready)
        begin
            tx_dvalid <= 1'b0;
            tx_eof    <= 1'b0;
        end
    end

    // words handed to the link since the last setup frame; a setup frame arriving
    // while the previous frame still drains would miscount, the drive never does that
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || flush || (rx_hdr_valid && rx_kind == pcs_pkg::FR_PIO_SET))
            sent_r <= 16'h0000;
        else if (tx_pop)
            sent_r <= sent_r + 16'h0001;
    end

    // dma staging holds each word until the engine takes it
    assign dma_take      = to_dma && rx_dvalid && rx_dready;
    assign dma_valid_nxt = dma_take || (dma_valid && !dma_ready);

    // receive and dma flow control outputs; ready is registered, so it is only
    // offered where a word taken next cycle cannot overrun fifo or staging
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rx_dready <= 1'b0;
            dma_valid <= 1'b0;
            dma_word  <= 16'h0000;
        end
        else
        begin
            rx_dready <= to_dma ? !dma_valid_nxt
                                : (phase_r == PH_IN && rx_in_ready && !rx_push);
            dma_valid <= dma_valid_nxt;
            if (dma_take)
                dma_word <= rx_dword;
        end
    end

    // outbound register frame toward the drive
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            h2d_valid <= 1'b0;
            h2d_frame <= '0;
        end
        else if (flush)
        begin
            h2d_valid         <= 1'b1;
            h2d_frame.cmdblk  <= cmdblk_r;
            h2d_frame.ctrl    <= ctrl_r;
            h2d_frame.command <= pwdata[7:0];
        end
        else if (h2d_ack)
            h2d_valid <= 1'b0;
    end

    // sequencing of shadow status, held setup context and counts
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase_r  <= PH_IDLE;
            status_r <= pcs_pkg::STATUS_RST;
            error_r  <= 8'h00;
            held_r   <= 1'b0;
            hold_r   <= '0;
            cnt_r    <= 16'h0000;
            done_r   <= 16'h0000;
            eof_r    <= 1'b0;
            cmdblk_r <= 32'h0000_0000;
        end
        else
        begin
            if (wr_acc && paddr == pcs_pkg::REG_CMDBLK)
                cmdblk_r <= pwdata;
            if (flush)
            begin
                status_r <= 8'h80;
                phase_r  <= dma_run_r ? PH_DMA : PH_IDLE;
                held_r   <= 1'b0;
                eof_r    <= 1'b0;
            end
            else if (rx_hdr_valid && rx_kind == pcs_pkg::FR_PIO_SET)
            begin
                cnt_r  <= rx_rdcnt(rx_hdr.count);
                done_r <= 16'h0000;
                hold_r <= rx_hdr;
                if (rx_hdr.dir_in)
                begin
                    held_r  <= 1'b1;
                    phase_r <= PH_IN;
                end
                else
                begin
                    status_r <= rx_hdr.status;
                    error_r  <= rx_hdr.error;
                    phase_r  <= PH_OUT;
                    eof_r    <= 1'b0;
                end
            end
            else if (rx_hdr_valid && rx_kind == pcs_pkg::FR_DATA && held_r)
            begin
                held_r   <= 1'b0;
                status_r <= hold_r.status;
                error_r  <= hold_r.error;
                cmdblk_r <= hold_r.regs;
            end
            else if (rx_hdr_valid && rx_kind == pcs_pkg::FR_REG_D2H)
            begin
                if (!rx_hdr.status[pcs_pkg::ST_BSY])
                begin
                    status_r <= rx_hdr.status;
                    error_r  <= rx_hdr.error;
                    cmdblk_r <= rx_hdr.regs;
                    phase_r  <= PH_IDLE;
                end
            end
            else if (phase_r == PH_OUT && tx_push)
            begin
                done_r <= done_r + 16'h0001;
                if (done_r + 16'h0001 == cnt_r)
                begin
                    status_r <= hold_r.e_status;
                    eof_r    <= 1'b1;
                    // an armed engine must still catch the data frame after the packet
                    phase_r  <= dma_run_r ? PH_DMA : PH_IDLE;
                end
            end
            else if (phase_r == PH_IN && !held_r)
            begin
                if (rx_push)
                    done_r <= done_r + 16'h0001;
                if (done_r == cnt_r && !rx_out_valid && status_r[pcs_pkg::ST_DRQ])
                begin
                    status_r <= hold_r.e_status;
                    phase_r  <= PH_IDLE;
                end
            end
        end
    end

    function automatic logic [15:0] rx_rdcnt(input logic [15:0] c);
        rx_rdcnt = c;
    endfunction

    // sticky events: set beats a same-cycle clear
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_nxt;
    logic [EV_W-1:0] mask_nxt;
    always_comb
    begin
        ev_set = '0;
        ev_set[pcs_pkg::EV_SETUP] = (rx_hdr_valid && rx_kind == pcs_pkg::FR_PIO_SET
                                     && !rx_hdr.dir_in && rx_hdr.irq)
                                  || (rx_hdr_valid && rx_kind == pcs_pkg::FR_DATA
                                     && held_r && hold_r.irq);
        ev_set[pcs_pkg::EV_DONE]  = rx_hdr_valid && rx_kind == pcs_pkg::FR_REG_D2H
                                  && !rx_hdr.status[pcs_pkg::ST_BSY] && rx_hdr.irq;
        ev_nxt   = ev_r;
        mask_nxt = mask_r;
        if (wr_acc && paddr == pcs_pkg::REG_IRQSTAT)
            ev_nxt = ev_r & ~pwdata[EV_W-1:0];
        if (wr_acc && paddr == pcs_pkg::REG_IRQMASK)
            mask_nxt = pwdata[EV_W-1:0];
        ev_nxt = ev_nxt | ev_set;
    end

    // control registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ev_r      <= '0;
            mask_r    <= '0;
            ctrl_r    <= 8'h00;
            cmd_r     <= 8'h00;
            dma_run_r <= 1'b0;
            dma_dir_r <= 1'b0;
            irq       <= 1'b0;
        end
        else
        begin
            ev_r   <= ev_nxt;
            mask_r <= mask_nxt;
            // next values keep irq in step with a mask write as well
            irq    <= |(ev_nxt & mask_nxt);
            if (wr_acc && paddr == pcs_pkg::REG_CTRL)
                ctrl_r <= pwdata[7:0];
            if (flush)
                cmd_r <= pwdata[7:0];
            if (wr_acc && paddr == pcs_pkg::REG_DMACTL)
            begin
                dma_run_r <= pwdata[0];
                dma_dir_r <= pwdata[1];
            end
        end
    end

    // read mux
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr)
            pcs_pkg::REG_CMDBLK:  rdata_nxt = cmdblk_r;
            pcs_pkg::REG_CTRL:    rdata_nxt = {24'h000000, ctrl_r};
            pcs_pkg::REG_STATUS:  rdata_nxt = {16'h0000, error_r, status_r};
            pcs_pkg::REG_CMD:     rdata_nxt = {24'h000000, cmd_r};
            pcs_pkg::REG_DATA:    rdata_nxt = {16'h0000, rx_out_valid ? rx_out_data : 16'h0000};
            pcs_pkg::REG_DMACTL:  rdata_nxt = {30'h0, dma_dir_r, dma_run_r};
            pcs_pkg::REG_IRQSTAT: rdata_nxt = {30'h0, ev_r};
            pcs_pkg::REG_IRQMASK: rdata_nxt = {30'h0, mask_r};
            pcs_pkg::REG_XFER:    rdata_nxt = {phase_r, 14'h0000, cnt_r};
            default:              rdata_nxt = 32'h0000_0000;
        endcase
    end

    // apb answer: pready high in the access cycle of every transfer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            prdata  <= rdata_nxt;
            pslverr <= psel && !penable && !known;
        end
    end

    // assertions
    property p_busy_on_cmd;
        @(posedge core_clk) disable iff (!rst_n)
        flush |=> status_r[pcs_pkg::ST_BSY] && h2d_valid;
    endproperty
    a_busy_on_cmd: assert property (p_busy_on_cmd) else $error("busy not set");

    property p_setup_out;
        @(posedge core_clk) disable iff (!rst_n)
        rx_hdr_valid && rx_kind == pcs_pkg::FR_PIO_SET && !rx_hdr.dir_in && !flush
        |=> status_r == $past(rx_hdr.status);
    endproperty
    a_setup_out: assert property (p_setup_out) else $error("setup status not loaded");

    property p_hold_in;
        @(posedge core_clk) disable iff (!rst_n)
        rx_hdr_valid && rx_kind == pcs_pkg::FR_PIO_SET && rx_hdr.dir_in && !flush
        |=> held_r && $stable(status_r);
    endproperty
    a_hold_in: assert property (p_hold_in) else $error("setup applied early");

    property p_data_apply;
        @(posedge core_clk) disable iff (!rst_n)
        rx_hdr_valid && rx_kind == pcs_pkg::FR_DATA && held_r && !flush
        |=> !held_r && status_r == $past(hold_r.status);
    endproperty
    a_data_apply: assert property (p_data_apply) else $error("held setup not applied");

    property p_irq_level;
        @(posedge core_clk) disable iff (!rst_n)
        irq == (|(ev_r & mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not level of events");

    property p_done_irq;
        @(posedge core_clk) disable iff (!rst_n)
        ev_set[pcs_pkg::EV_DONE] |=> ev_r[pcs_pkg::EV_DONE];
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("completion event lost");

    property p_cmpl;
        @(posedge core_clk) disable iff (!rst_n)
        rx_hdr_valid && rx_kind == pcs_pkg::FR_REG_D2H && !rx_hdr.status[pcs_pkg::ST_BSY]
        && !flush |=> !status_r[pcs_pkg::ST_BSY] && phase_r == PH_IDLE;
    endproperty
    a_cmpl: assert property (p_cmpl) else $error("completion not applied");

    property p_no_push_idle;
        @(posedge core_clk) disable iff (!rst_n)
        tx_push |-> phase_r == PH_OUT;
    endproperty
    a_no_push_idle: assert property (p_no_push_idle) else $error("push outside out phase");

    property p_dma_hold;
        @(posedge core_clk) disable iff (!rst_n)
        dma_valid && !dma_ready |=> dma_valid && $stable(dma_word);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma word dropped");

    property p_rst;
        @(posedge core_clk)
        !rst_n |=> !status_r[pcs_pkg::ST_DRQ] && !held_r && !rx_out_valid;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

// >>> verification/packet_command_shadow_sequencer_tb.sv
// packet_command_shadow_sequencer_tb: self-checking bench of pcs_top
// assumes: pcs_drive_model on the link side, APB master tasks here
module packet_command_shadow_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                h2d_valid, h2d_ack, rx_hdr_valid, rx_dvalid, rx_dready;
    logic                tx_dvalid, tx_dready, tx_eof, dma_valid, dma_ready;
    logic [15:0]         rx_dword, tx_dword, dma_word, seed;
    logic [15:0]         w[8];
    pcs_pkg::pcs_h2d_t   h2d_frame;
    pcs_pkg::pcs_frame_t rx_kind;
    pcs_pkg::pcs_hdr_t   rx_hdr, h;
    int                  miscompares, n_checks, cyc;

    pcs_top uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .h2d_valid, .h2d_frame, .h2d_ack, .rx_hdr_valid, .rx_kind,
        .rx_hdr, .rx_dvalid, .rx_dready, .rx_dword, .tx_dvalid, .tx_dready, .tx_dword,
        .tx_eof, .dma_valid, .dma_word, .dma_ready);
    pcs_drive_model drv (.core_clk, .h2d_valid, .h2d_frame, .h2d_ack, .rx_hdr_valid,
        .rx_kind, .rx_hdr, .rx_dvalid, .rx_dready, .rx_dword, .tx_dvalid, .tx_eof,
        .tx_dword, .tx_dready, .dma_valid, .dma_word, .dma_ready);

    // 40 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (!pready);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st(input logic [7:0] s, input logic i);
        apb(1'b0, pcs_pkg::REG_STATUS, 32'h0);
        chk(rd[7:0], s);
        chk(irq, i);
    endtask

    task automatic fill();
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            w[i] = seed;
        end
    endtask

    // setup frame: begin status drq, end status busy without drq
    task automatic setup(input logic [15:0] n, input logic din, input logic fi);
        h = '0;
        h.status = 8'h48;
        h.e_status = 8'hC0;
        h.count = n;
        h.dir_in = din;
        h.irq = fi;
        drv.hdr(pcs_pkg::FR_PIO_SET, h);
    endtask

    task automatic done(input logic fi);
        h = '0;
        h.status = 8'h50;
        h.irq = fi;
        drv.hdr(pcs_pkg::FR_REG_D2H, h);
    endtask

    task automatic issue();
        seed = lfsr(seed);
        apb(1'b1, pcs_pkg::REG_CMDBLK, {seed, ~seed});
        apb(1'b1, pcs_pkg::REG_CTRL, 32'h08);
        apb(1'b1, pcs_pkg::REG_CMD, 32'hA0);
        do @(posedge core_clk); while (!h2d_ack);
        chk(drv.got, {seed, ~seed, 8'h08, 8'hA0});
        st(8'h80, 1'b0);
    endtask

    // outbound phase of n words; eof only on the last
    task automatic outp(input int n, input logic fi);
        setup(n[15:0], 1'b0, fi);
        st(8'h48, fi);
        fill();
        for (int i = 0; i < n; i++) apb(1'b1, pcs_pkg::REG_DATA, {16'h0, w[i]});
        while (drv.txq.size() < n) @(posedge core_clk);
        for (int i = 0; i < n; i++) chk(drv.txq.pop_front(), {i == n - 1, w[i]});
        st(8'hC0, fi);
        if (fi) apb(1'b1, pcs_pkg::REG_IRQSTAT, 32'h1);
    endtask

    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 16'h710E;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        st(8'h00, 1'b0);
        apb(1'b0, 8'h24, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, pcs_pkg::REG_IRQMASK, 32'h3);
        issue();
        outp(6, 1'b0);
        setup(16'h8, 1'b1, 1'b1);
        st(8'hC0, 1'b0);
        drv.hdr(pcs_pkg::FR_DATA, '0);
        fill();
        drv.words(w);
        st(8'h48, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, pcs_pkg::REG_DATA, 32'h0);
            chk(rd[15:0], w[i]);
        end
        st(8'hC0, 1'b1);
        apb(1'b1, pcs_pkg::REG_IRQSTAT, 32'h1);
        done(1'b1);
        st(8'h50, 1'b1);
        apb(1'b1, pcs_pkg::REG_IRQMASK, 32'h0);
        st(8'h50, 1'b0);
        apb(1'b0, pcs_pkg::REG_IRQSTAT, 32'h0);
        chk(rd[1:0], 2'h2);
        apb(1'b1, pcs_pkg::REG_IRQSTAT, 32'h2);
        apb(1'b1, pcs_pkg::REG_IRQMASK, 32'h3);
        st(8'h50, 1'b0);
        $display("test pio data-in done");
        issue();
        outp(6, 1'b0);
        outp(4, 1'b1);
        $display("test pio data-out done");
        apb(1'b1, pcs_pkg::REG_DMACTL, 32'h3);
        issue();
        outp(6, 1'b0);
        drv.hdr(pcs_pkg::FR_DATA, '0);
        fill();
        drv.words(w);
        while (drv.dmq.size() < 8) @(posedge core_clk);
        for (int i = 0; i < 8; i++) chk(drv.dmq.pop_front(), w[i]);
        done(1'b0);
        st(8'h50, 1'b0);
        $display("test dma data-in done");
        summarize();
    end
endmodule

// >>> verification/pcs_drive_model.sv
// pcs_drive_model: attached drive on the far side of the link
// assumes: the bench calls hdr and words just after a rising edge
module pcs_drive_model
(
    input  wire logic                core_clk,
    input  wire logic                h2d_valid,
    input  wire pcs_pkg::pcs_h2d_t   h2d_frame,
    output logic                     h2d_ack,
    output logic                     rx_hdr_valid,
    output pcs_pkg::pcs_frame_t      rx_kind,
    output pcs_pkg::pcs_hdr_t        rx_hdr,
    output logic                     rx_dvalid,
    input  wire logic                rx_dready,
    output logic [15:0]              rx_dword,
    input  wire logic                tx_dvalid,
    input  wire logic                tx_eof,
    input  wire logic [15:0]         tx_dword,
    output logic                     tx_dready,
    input  wire logic                dma_valid,
    input  wire logic [15:0]         dma_word,
    output logic                     dma_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    pcs_pkg::pcs_h2d_t got;
    logic [16:0]       txq[$];
    logic [15:0]       dmq[$];

    // idle link
    initial
    begin
        {h2d_ack, rx_hdr_valid, rx_dvalid, tx_dready, dma_ready} = '0;
        rx_kind = pcs_pkg::FR_DATA;
        rx_hdr = '0;
        rx_dword = 16'hFFFF;
    end

    // stalls both outbound streams every other cycle, so pacing is exercised
    always @(posedge core_clk)
    begin
        h2d_ack <= h2d_valid && !h2d_ack;
        if (h2d_valid && !h2d_ack) got <= h2d_frame;
        tx_dready <= !tx_dready;
        dma_ready <= !dma_ready;
        if (tx_dvalid && tx_dready) txq.push_back({tx_eof, tx_dword});
        if (dma_valid && dma_ready) dmq.push_back(dma_word);
    end

    // one header strobe; released header shows the inverse
    task automatic hdr(input pcs_pkg::pcs_frame_t k, input pcs_pkg::pcs_hdr_t h);
        @(posedge core_clk);
        rx_hdr_valid <= 1'b1;
        rx_kind <= k;
        rx_hdr <= h;
        @(posedge core_clk);
        rx_hdr_valid <= 1'b0;
        rx_hdr <= ~h;
    endtask

    // all words of one data frame, each held until ready is sampled
    task automatic words(input logic [15:0] w[8]);
        @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            rx_dvalid <= 1'b1;
            rx_dword <= w[i];
            @(posedge core_clk);
            while (!rx_dready) @(posedge core_clk);
        end
        rx_dvalid <= 1'b0;
        rx_dword <= ~w[7];
    endtask
endmodule
